/* File: src/sqe_pkg.sv */
package sqe_pkg;
    localparam int unsigned SQE_ADDR_W = 9;
    localparam int unsigned SQE_DATA_W = 16;
    localparam int unsigned SQE_NUM_REGS = 6;
    localparam int unsigned SQE_REG_IDX_W = 3;

    // byte offsets on the host register port
    localparam logic [SQE_ADDR_W-1:0] SQE_OFS_MQE_16_31 = 9'h15C;
    localparam logic [SQE_ADDR_W-1:0] SQE_OFS_MQE_0_15 = 9'h15E;
    localparam logic [SQE_ADDR_W-1:0] SQE_OFS_SQE_112_127 = 9'h160;
    localparam logic [SQE_ADDR_W-1:0] SQE_OFS_SQE_96_111 = 9'h162;
    localparam logic [SQE_ADDR_W-1:0] SQE_OFS_SQE_80_95 = 9'h164;
    localparam logic [SQE_ADDR_W-1:0] SQE_OFS_SQE_64_79 = 9'h166;

    localparam logic [SQE_DATA_W-1:0] SQE_RESET_VAL = 16'h0000;
    localparam logic [SQE_DATA_W-1:0] SQE_UNMAPPED_RD = 16'h0000;

    // register indices inside the bank
    localparam logic [SQE_REG_IDX_W-1:0] SQE_IDX_MQE_16_31 = 3'h0;
    localparam logic [SQE_REG_IDX_W-1:0] SQE_IDX_MQE_0_15 = 3'h1;
    localparam logic [SQE_REG_IDX_W-1:0] SQE_IDX_SQE_112_127 = 3'h2;
    localparam logic [SQE_REG_IDX_W-1:0] SQE_IDX_SQE_96_111 = 3'h3;
    localparam logic [SQE_REG_IDX_W-1:0] SQE_IDX_SQE_80_95 = 3'h4;
    localparam logic [SQE_REG_IDX_W-1:0] SQE_IDX_SQE_64_79 = 3'h5;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [SQE_ADDR_W-1:0] addr;
        logic [SQE_DATA_W-1:0] wdata;
    } sqe_req_t;

    typedef struct packed {
        logic [31:0] master_en;
        logic [63:0] slave_en;
    } sqe_enables_t;
endpackage : sqe_pkg

/* File: src/sqe_reg16.sv */
`timescale 1ns/1ps
module sqe_reg16
    import sqe_pkg::*;
#(
    parameter int unsigned W = SQE_DATA_W
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_we,
    input  wire logic [W-1:0] i_wdata,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] q_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_ff <= W'(SQE_RESET_VAL);
        end else if (i_we) begin
            q_ff <= i_wdata;
        end
    end

    assign o_q = q_ff;
endmodule : sqe_reg16

/* File: src/sqe_queue_enable_regs.sv */
`timescale 1ns/1ps
module sqe_queue_enable_regs
    import sqe_pkg::*;
(
    input  wire logic                  I_REF_CLK,
    input  wire logic                  I_RST_N,
    input  wire logic                  I_WR,
    input  wire logic                  I_RD,
    input  wire logic [SQE_ADDR_W-1:0] I_ADDR,
    input  wire logic [SQE_DATA_W-1:0] I_WDATA,
    input  wire logic                  I_SHARED_MODE,
    output logic      [SQE_DATA_W-1:0] O_RDATA,
    output logic                       O_RD_VALID,
    output logic      [31:0]           O_MASTER_QUEUE_EN,
    output logic      [63:0]           O_SLAVE_QUEUE_EN
);
    sqe_req_t                  req;
    logic [SQE_DATA_W-1:0]     regs [SQE_NUM_REGS];
    logic [SQE_DATA_W-1:0]     rdata_ff;
    logic                      rd_valid_ff;
    logic [SQE_DATA_W-1:0]     nxt_rdata;
    sqe_enables_t              en;

    assign req = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};

    // one decode shared by write strobes and read mux
    function automatic logic [SQE_REG_IDX_W:0] decode(
        input logic [SQE_ADDR_W-1:0] a
    );
        logic [SQE_REG_IDX_W:0] r;
        r = '0;
        unique case (a)
            SQE_OFS_MQE_16_31:   r = {1'b1, SQE_IDX_MQE_16_31};
            SQE_OFS_MQE_0_15:    r = {1'b1, SQE_IDX_MQE_0_15};
            SQE_OFS_SQE_112_127: r = {1'b1, SQE_IDX_SQE_112_127};
            SQE_OFS_SQE_96_111:  r = {1'b1, SQE_IDX_SQE_96_111};
            SQE_OFS_SQE_80_95:   r = {1'b1, SQE_IDX_SQE_80_95};
            SQE_OFS_SQE_64_79:   r = {1'b1, SQE_IDX_SQE_64_79};
            default:             r = '0;
        endcase
        return r;
    endfunction : decode

    logic [SQE_REG_IDX_W:0] hit;
    assign hit = decode(req.addr);

    // writes to unmapped offsets are dropped silently
    genvar g;
    generate
        for (g = 0; g < SQE_NUM_REGS; g++) begin : g_reg
            sqe_reg16 #(.W(SQE_DATA_W)) u_reg (
                .i_clk   (I_REF_CLK),
                .i_rst_n (I_RST_N),
                .i_we    (req.wr && hit[SQE_REG_IDX_W] &&
                          hit[SQE_REG_IDX_W-1:0] ==
                          SQE_REG_IDX_W'(g)),
                .i_wdata (req.wdata),
                .o_q     (regs[g])
            );
        end
    endgenerate

    always_comb begin
        nxt_rdata = SQE_UNMAPPED_RD;
        if (hit[SQE_REG_IDX_W]) begin
            nxt_rdata = regs[hit[SQE_REG_IDX_W-1:0]];
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdata_ff    <= SQE_RESET_VAL;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= req.rd;
            if (req.rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // lsb of each register is the lowest queue of its range
    assign en.master_en[15:0]  = regs[SQE_IDX_MQE_0_15];
    assign en.master_en[31:16] = regs[SQE_IDX_MQE_16_31];
    assign en.slave_en[15:0]   = regs[SQE_IDX_SQE_64_79];
    assign en.slave_en[31:16]  = regs[SQE_IDX_SQE_80_95];
    assign en.slave_en[47:32]  = regs[SQE_IDX_SQE_96_111];
    assign en.slave_en[63:48]  = regs[SQE_IDX_SQE_112_127];

    // master enables apply in every mode, since software sets them anyway
    assign O_MASTER_QUEUE_EN = en.master_en;
    // slave enables are gated off outside shared mode
    assign O_SLAVE_QUEUE_EN  = I_SHARED_MODE ? en.slave_en
                                             : '0;
    assign O_RDATA    = rdata_ff;
    assign O_RD_VALID = rd_valid_ff;
endmodule : sqe_queue_enable_regs

/* File: dv/sqe_queue_enable_regs_assertions.sv */
`timescale 1ns/1ps
module sqe_chk
    import sqe_pkg::*;
(
    input wire logic                  I_REF_CLK,
    input wire logic                  I_RST_N,
    input wire logic                  I_WR,
    input wire logic                  I_RD,
    input wire logic [SQE_ADDR_W-1:0] I_ADDR,
    input wire logic [SQE_DATA_W-1:0] I_WDATA,
    input wire logic                  I_SHARED_MODE,
    input wire logic [SQE_DATA_W-1:0] O_RDATA,
    input wire logic                  O_RD_VALID,
    input wire logic [31:0]           O_MASTER_QUEUE_EN,
    input wire logic [63:0]           O_SLAVE_QUEUE_EN
);
    wire [95:0] en = {O_MASTER_QUEUE_EN, O_SLAVE_QUEUE_EN};
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    // register i sits at 0x15C + 2i; slave copies are only seen in shared mode
    property p_w(int i);
        (I_WR && I_ADDR == SQE_OFS_MQE_16_31 + 2 * i)
            ##1 (i < 2 || I_SHARED_MODE)
        |-> en[(5 - i) * 16 +: 16] == $past(I_WDATA);
    endproperty
    a_mst_hi_map: assert property (p_w(0))
        else $error("master 16 to 31 map");
    a_mst_lo_map: assert property (p_w(1))
        else $error("master 0 to 15 map");
    a_slv_112_map: assert property (p_w(2))
        else $error("slave 112 to 127 map");
    a_slv_96_map: assert property (p_w(3))
        else $error("slave 96 to 111 map");
    a_slv_80_map: assert property (p_w(4))
        else $error("slave 80 to 95 map");
    a_slv_64_map: assert property (p_w(5))
        else $error("slave 64 to 79 map");
    a_rd_pulse: assert property (O_RD_VALID == $past(I_RD))
        else $error("read valid");
    a_slv_gate: assert property (!I_SHARED_MODE |->
        O_SLAVE_QUEUE_EN == 64'h0)
        else $error("slave gate");
    c_shared_wr: cover property (I_WR && I_SHARED_MODE);
    c_rd_wr: cover property (I_RD && I_WR);
    c_rd_done: cover property (I_RD ##1 O_RD_VALID);
endmodule : sqe_chk
bind sqe_queue_enable_regs sqe_chk sqe_chk_inst (.I_REF_CLK, .I_RST_N,
    .I_WR, .I_RD, .I_ADDR, .I_WDATA, .I_SHARED_MODE, .O_RDATA, .O_RD_VALID,
    .O_MASTER_QUEUE_EN, .O_SLAVE_QUEUE_EN);

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import sqe_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, sh = 0, rd_valid;
    logic [8:0]  addr = '0;
    logic [15:0] wdata = '0, rd_data, m [6], exp_q [$];
    logic [31:0] mst;
    logic [63:0] slv;
    int          fail_count = 0, checks_done = 0;
    always #4 clk = ~clk;
    sqe_queue_enable_regs sqe_queue_enable_regs_inst (.I_REF_CLK(clk),
        .I_RST_N(rst_n), .I_WR(wr), .I_RD(rd), .I_ADDR(addr), .I_WDATA(wdata),
        .I_SHARED_MODE(sh), .O_RDATA(rd_data), .O_RD_VALID(rd_valid),
        .O_MASTER_QUEUE_EN(mst), .O_SLAVE_QUEUE_EN(slv));
    task chk(string n, logic [63:0] e, logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task summarize;
        if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // one bus cycle; the model keeps old data for a read in a write cycle
    task op(bit w, bit r, logic [8:0] a, logic [15:0] d);
        int i;
        bit ok;
        i = (a - SQE_OFS_MQE_16_31) >> 1;
        ok = a >= SQE_OFS_MQE_16_31 && a <= SQE_OFS_SQE_64_79 && !a[0];
        @(posedge clk);
        {wr, rd, addr, wdata} <= {w, r, a, d};
        if (r) exp_q.push_back(ok ? m[i] : SQE_UNMAPPED_RD);
        if (w && ok) m[i] = d;
    endtask : op
    // seventh slot (0x168) is unmapped on purpose
    task sweep(bit w, bit r);
        for (int k = 0; k < 7; k++)
            op(w, r && (!w || k == 3), SQE_OFS_MQE_16_31 + 9'(2 * k),
               16'($urandom));
    endtask : sweep
    task chk_en;
        op(0, 0, '0, '0);
        #1 chk("master_en", {m[0], m[1]}, mst);
        chk("slave_en", sh ? {m[2], m[3], m[4], m[5]} : 64'h0,
            slv);
    endtask : chk_en
    always @(posedge clk) if (rd_valid === 1'b1)
        chk("rd_data", exp_q.size() ? exp_q.pop_front() : 'x,
            rd_data);
    initial begin
        #100000 fail_count++;
        summarize();
    end
    initial begin
        void'($urandom(32'hB365B8CB));
        foreach (m[k]) m[k] = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1;
        sweep(0, 1);
        sh <= 1;
        repeat (2) begin
            sweep(1, 1);
            chk_en();
        end
        @(posedge clk) sh <= 0;
        sweep(1, 0);
        sweep(0, 1);
        chk_en();
        @(posedge clk) rst_n <= 0;
        foreach (m[k]) m[k] = '0;
        @(posedge clk) rst_n <= 1;
        sweep(0, 1);
        chk_en();
        repeat (3) op(0, 0, '0, '0);
        chk("rd_pending", 0, exp_q.size());
        summarize();
    end
endmodule : tb_top
